// [verilog/gdf_pkg.sv]
// Package for the gate driver fault report mask block.
// Assumes a single 40 MHz clock domain and one register write port.
package gdf_pkg;

  // ----------------------------------------------------------------
  // Register selection and widths
  // ----------------------------------------------------------------
  localparam int GDF_REG_W = 16;
  localparam logic GDF_SEL_MASKS = 1'h0;    // fault_pin_report_masks
  localparam logic GDF_SEL_FAILSAFE = 1'h1; // failsafe_output_states

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] GDF_MASKS_RST = 16'h8940;
  localparam logic [15:0] GDF_FAILSAFE_RST = 16'hC008;

  // ----------------------------------------------------------------
  // fault_pin_report_masks field positions
  // ----------------------------------------------------------------
  localparam int GDF_M_SPARE = 15;
  localparam int GDF_M_SHORT = 14;
  localparam int GDF_M_OVERCUR = 13;
  localparam int GDF_M_GM_HI = 12;
  localparam int GDF_M_GM_LO = 11;
  localparam int GDF_M_UNDERV = 10;
  localparam int GDF_M_OVERV = 9;
  localparam int GDF_M_SW_OT = 8;
  localparam int GDF_M_DRV_OT = 7;
  localparam int GDF_M_LINK = 6;
  localparam int GDF_M_CFG_CRC = 5;
  localparam int GDF_M_TRIM_CRC = 4;
  localparam int GDF_M_REG = 3;
  localparam int GDF_M_SELF_TEST = 2;
  localparam int GDF_M_ILIMIT = 1;
  localparam int GDF_M_CLK_MON = 0;

  // ----------------------------------------------------------------
  // failsafe_output_states field positions
  // ----------------------------------------------------------------
  localparam int GDF_F_OTW_EN = 15;
  localparam int GDF_F_RESERVED = 10;
  localparam int GDF_F_GM_HI = 3;
  localparam int GDF_F_GM_LO = 2;

  // ----------------------------------------------------------------
  // Checksum and encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] GDF_CRC_POLY = 8'h07;
  localparam logic [7:0] GDF_CRC_INIT = 8'hFF;

  typedef enum logic [1:0] {
    GDF_GM_MASKED = 2'b00,
    GDF_GM_ALARM = 2'b01,
    GDF_GM_WARN = 2'b10,
    GDF_GM_LIVE = 2'b11
  } gdf_gm_route_e;

  typedef enum logic [1:0] {
    GDF_FS_LOW = 2'b00,
    GDF_FS_HIGH = 2'b01,
    GDF_FS_HIZ = 2'b10,
    GDF_FS_NONE = 2'b11
  } gdf_failsafe_e;

endpackage

// [verilog/gdf_config_crc.sv]
// Checksum over the two configuration registers.
// Assumes registered inputs from the owning block, same clock and reset.
`timescale 1ns/1ps
module gdf_config_crc
  import gdf_pkg::*;
#(
  parameter int DATA_W = 32
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Data covered
  input wire logic [DATA_W-1:0] data_in,
  // Checksum
  output logic [7:0] crc_out
);

  // ----------------------------------------------------------------
  // Checks and checksum function
  // ----------------------------------------------------------------
  if (DATA_W < 8) begin : g_bad_data_w
    $error("gdf_config_crc: DATA_W below 8");
  end

  function automatic logic [7:0] gdf_crc8(input logic [DATA_W-1:0] d);
    logic [7:0] c;
    c = GDF_CRC_INIT;
    for (int i = DATA_W - 1; i >= 0; i--) begin
      if (c[7] ^ d[i]) begin
        c = {c[6:0], 1'b0} ^ GDF_CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction

  // Checksum state
  typedef struct packed {
    logic [7:0] crc;
  } gdf_crc_s;

  gdf_crc_s st;
  gdf_crc_s next_st;

  // Next checksum from the covered registers
  always_comb begin
    next_st = st;
    next_st.crc = gdf_crc8(data_in);
  end

  // Registered checksum, zero while in reset
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign crc_out = st.crc;

endmodule

// [verilog/gdf_fault_report.sv]
// Fault report routing for the secondary side of a gate driver.
// Assumes fault detector levels synchronous to clk_in and a register
// write port driven by the serial configuration logic.
`timescale 1ns/1ps
module gdf_fault_report
  import gdf_pkg::*;
#(
  parameter int REG_W = GDF_REG_W
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic cfg_wr_in,
  input wire logic cfg_wr_sel_in,
  input wire logic [REG_W-1:0] cfg_wdata_in,
  input wire logic cfg_rd_sel_in,
  input wire logic cfg_fault_clr_in,
  output logic [REG_W-1:0] cfg_rdata_out,
  // Fault detector levels
  input wire logic short_circuit_in,
  input wire logic overcurrent_in,
  input wire logic gate_monitor_in,
  input wire logic gate_voltage_high_in,
  input wire logic supply_undervoltage_in,
  input wire logic supply_overvoltage_in,
  input wire logic switch_overtemp_in,
  input wire logic driver_overtemp_in,
  input wire logic driver_overtemp_warn_in,
  input wire logic internal_link_in,
  input wire logic config_checksum_in,
  input wire logic trim_checksum_in,
  input wire logic internal_regulator_in,
  input wire logic self_test_in,
  input wire logic regulator_ilimit_in,
  input wire logic clock_monitor_in,
  // Fault pins
  output logic fault_alarm_n_out,
  output logic fault_warning_n_out,
  // Protective actions and status
  output logic secondary_shutdown_out,
  output logic gate_monitor_failsafe_active_out,
  output logic [1:0] gate_monitor_failsafe_state_out,
  output logic driver_overtemp_warning_out,
  output logic config_fault_out,
  output logic [13:0] detected_faults_out,
  output logic [7:0] secondary_config_checksum_out
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (REG_W != GDF_REG_W) begin : g_bad_reg_w
    $error("gdf_fault_report: REG_W must be 16");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] masks;
    logic [15:0] failsafe;
    logic cfg_fault;
    logic alarm_n;
    logic warn_n;
    logic shutdown;
    logic gm_act;
    logic [1:0] gm_state;
    logic otw;
    logic [13:0] raw;
    logic [15:0] rdata;
  } gdf_state_s;

  localparam gdf_state_s GDF_STATE_RST = '{
    masks: GDF_MASKS_RST,
    failsafe: GDF_FAILSAFE_RST,
    cfg_fault: 1'h0,
    alarm_n: 1'h1,
    warn_n: 1'h1,
    shutdown: 1'h0,
    gm_act: 1'h0,
    gm_state: GDF_FS_NONE,
    otw: 1'h0,
    raw: 14'h0000,
    rdata: 16'h0000
  };

  gdf_state_s st;
  gdf_state_s next_st;
  gdf_gm_route_e gm_route;
  logic cfg_crc_fault;
  logic alarm;
  logic warn;

  // Report route decode, used for pin logic and checks
  function automatic gdf_gm_route_e gdf_route(input logic [15:0] m);
    return gdf_gm_route_e'(m[GDF_M_GM_HI:GDF_M_GM_LO]);
  endfunction

  assign gm_route = gdf_route(st.masks);
  // Checksum fault from outside or reserved-bit write
  assign cfg_crc_fault = config_checksum_in | st.cfg_fault;

  // ----------------------------------------------------------------
  // Alarm and warning combination
  // ----------------------------------------------------------------
  always_comb begin
    alarm = 1'b0;
    warn = 1'b0;
    alarm = alarm | (short_circuit_in & ~st.masks[GDF_M_SHORT]);
    alarm = alarm | (overcurrent_in & ~st.masks[GDF_M_OVERCUR]);
    case (gm_route)
      GDF_GM_MASKED: begin
      end
      GDF_GM_ALARM: alarm = alarm | gate_monitor_in;
      GDF_GM_WARN: warn = warn | gate_monitor_in;
      GDF_GM_LIVE: warn = warn | gate_voltage_high_in;
      default: begin
      end
    endcase
    alarm = alarm
      | (supply_undervoltage_in & ~st.masks[GDF_M_UNDERV]);
    alarm = alarm
      | (supply_overvoltage_in & ~st.masks[GDF_M_OVERV]);
    alarm = alarm | (switch_overtemp_in & st.masks[GDF_M_SW_OT]);
    alarm = alarm | (driver_overtemp_in & ~st.masks[GDF_M_DRV_OT]);
    alarm = alarm | (internal_link_in & st.masks[GDF_M_LINK]);
    alarm = alarm | (cfg_crc_fault & ~st.masks[GDF_M_CFG_CRC]);
    // Trim checksum drives both pins
    alarm = alarm | (trim_checksum_in & ~st.masks[GDF_M_TRIM_CRC]);
    warn = warn | (trim_checksum_in & ~st.masks[GDF_M_TRIM_CRC]);
    alarm = alarm | (internal_regulator_in & ~st.masks[GDF_M_REG]);
    alarm = alarm | (self_test_in & ~st.masks[GDF_M_SELF_TEST]);
    warn = warn | (self_test_in & ~st.masks[GDF_M_SELF_TEST]);
    alarm = alarm | (regulator_ilimit_in & ~st.masks[GDF_M_ILIMIT]);
    alarm = alarm | (clock_monitor_in & ~st.masks[GDF_M_CLK_MON]);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    // Register writes; spare bits store like any other bit
    if (cfg_wr_in && cfg_wr_sel_in == GDF_SEL_MASKS) begin
      next_st.masks = cfg_wdata_in;
    end
    if (cfg_wr_in && cfg_wr_sel_in == GDF_SEL_FAILSAFE) begin
      next_st.failsafe = cfg_wdata_in;
    end
    // Sticky config fault, set wins over clear
    if (cfg_fault_clr_in) begin
      next_st.cfg_fault = 1'b0;
    end
    if (cfg_wr_in && cfg_wr_sel_in == GDF_SEL_FAILSAFE
        && cfg_wdata_in[GDF_F_RESERVED]) begin
      next_st.cfg_fault = 1'b1;
    end
    // Pins, active low
    next_st.alarm_n = ~alarm;
    next_st.warn_n = ~warn;
    // Protective shutdown ignores the report mask
    next_st.shutdown = driver_overtemp_in;
    // Gate monitor failsafe action
    next_st.gm_act = gate_monitor_in;
    if (gate_monitor_in) begin
      next_st.gm_state =
        st.failsafe[GDF_F_GM_HI:GDF_F_GM_LO];
    end else begin
      next_st.gm_state = GDF_FS_NONE;
    end
    next_st.otw = driver_overtemp_warn_in
      & st.failsafe[GDF_F_OTW_EN];
    // Raw detection, unaffected by masks
    next_st.raw = {short_circuit_in, overcurrent_in, gate_monitor_in,
      supply_undervoltage_in, supply_overvoltage_in, switch_overtemp_in,
      driver_overtemp_in, internal_link_in, cfg_crc_fault,
      trim_checksum_in, internal_regulator_in, self_test_in,
      regulator_ilimit_in, clock_monitor_in};
    // Read data
    if (cfg_rd_sel_in == GDF_SEL_MASKS) begin
      next_st.rdata = st.masks;
    end else begin
      next_st.rdata = st.failsafe;
    end
  end

  // State register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= GDF_STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs and checksum
  // ----------------------------------------------------------------
  assign cfg_rdata_out = st.rdata;
  assign fault_alarm_n_out = st.alarm_n;
  assign fault_warning_n_out = st.warn_n;
  assign secondary_shutdown_out = st.shutdown;
  assign gate_monitor_failsafe_active_out = st.gm_act;
  assign gate_monitor_failsafe_state_out = st.gm_state;
  assign driver_overtemp_warning_out = st.otw;
  assign config_fault_out = st.cfg_fault;
  assign detected_faults_out = st.raw;

  // Checksum covers both registers, spare bits included
  gdf_config_crc #(
    .DATA_W(32)
  ) u_crc (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .data_in({st.masks, st.failsafe}),
    .crc_out(secondary_config_checksum_out)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_spare_no_fault: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (cfg_wr_in && cfg_wr_sel_in == GDF_SEL_MASKS && !st.cfg_fault)
      |=> !st.cfg_fault)
    else $error("mask write raised config fault");

  a_short_report: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (short_circuit_in && !st.masks[GDF_M_SHORT]) |=> !fault_alarm_n_out)
    else $error("short circuit not on alarm pin");

  a_overcur_report: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (overcurrent_in && !st.masks[GDF_M_OVERCUR]) |=> !fault_alarm_n_out)
    else $error("overcurrent not on alarm pin");

  a_gm_live_warn: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (gm_route == GDF_GM_LIVE && gate_voltage_high_in)
      |=> !fault_warning_n_out)
    else $error("live gate state missing on warning pin");

  a_gm_alarm_route: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (gm_route == GDF_GM_ALARM && gate_monitor_in) |=> !fault_alarm_n_out)
    else $error("gate monitor fault missing on alarm pin");

  a_underv_report: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (supply_undervoltage_in && !st.masks[GDF_M_UNDERV])
      |=> !fault_alarm_n_out)
    else $error("undervoltage not on alarm pin");

  a_overv_report: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (supply_overvoltage_in && !st.masks[GDF_M_OVERV])
      |=> !fault_alarm_n_out)
    else $error("overvoltage not on alarm pin");

  a_sw_ot_inverted: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (switch_overtemp_in && st.masks[GDF_M_SW_OT]) |=> !fault_alarm_n_out)
    else $error("switch overtemp not reported");

  a_drv_ot_report: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (driver_overtemp_in && !st.masks[GDF_M_DRV_OT]) |=> !fault_alarm_n_out)
    else $error("driver overtemp not on alarm pin");

  a_shutdown_always: assert property (
    @(posedge clk_in) disable iff (rst_in)
    driver_overtemp_in |=> secondary_shutdown_out)
    else $error("driver overtemp did not shut down");

  a_link_inverted: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (internal_link_in && st.masks[GDF_M_LINK]) |=> !fault_alarm_n_out)
    else $error("link fault not reported");

  a_cfg_crc_report: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (cfg_crc_fault && !st.masks[GDF_M_CFG_CRC]) |=> !fault_alarm_n_out)
    else $error("config checksum fault not on alarm pin");

  a_trim_both: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (trim_checksum_in && !st.masks[GDF_M_TRIM_CRC])
      |=> (!fault_alarm_n_out && !fault_warning_n_out))
    else $error("trim checksum fault not on fault pins");

  a_regulator_report: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (internal_regulator_in && !st.masks[GDF_M_REG]) |=> !fault_alarm_n_out)
    else $error("regulator fault not on alarm pin");

  a_self_test_both: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (self_test_in && !st.masks[GDF_M_SELF_TEST])
      |=> (!fault_alarm_n_out && !fault_warning_n_out))
    else $error("self test fault not on both pins");

  a_ilimit_report: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (regulator_ilimit_in && !st.masks[GDF_M_ILIMIT]) |=> !fault_alarm_n_out)
    else $error("current limit fault not on alarm pin");

  a_clk_mon_report: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (clock_monitor_in && !st.masks[GDF_M_CLK_MON]) |=> !fault_alarm_n_out)
    else $error("clock monitor fault not on alarm pin");

  a_gm_failsafe: assert property (
    @(posedge clk_in) disable iff (rst_in)
    gate_monitor_in |=> (gate_monitor_failsafe_state_out
      == $past(st.failsafe[GDF_F_GM_HI:GDF_F_GM_LO])))
    else $error("gate monitor failsafe state wrong");

  a_otw_gate: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !st.failsafe[GDF_F_OTW_EN] |=> !driver_overtemp_warning_out)
    else $error("overtemp warning passed while disabled");

  a_raw_kept: assert property (
    @(posedge clk_in) disable iff (rst_in)
    short_circuit_in |=> detected_faults_out[13])
    else $error("masked fault lost from detection");

  c_alarm_pin: cover property (@(posedge clk_in) disable iff (rst_in)
    $fell(fault_alarm_n_out));
  c_warn_pin: cover property (@(posedge clk_in) disable iff (rst_in)
    $fell(fault_warning_n_out));
  c_masked_short: cover property (@(posedge clk_in) disable iff (rst_in)
    short_circuit_in && st.masks[GDF_M_SHORT]);
  c_reserved_write: cover property (@(posedge clk_in) disable iff (rst_in)
    $rose(config_fault_out));

endmodule

// [testbench/gdf_host_monitor.sv]
// Host side model watching the two active-low fault pins.
// Assumes the pins are registered levels in the clk_in domain.
`timescale 1ns/1ps
module gdf_host_monitor (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Fault pins
  input wire logic fault_alarm_n_in,
  input wire logic fault_warning_n_in,
  // Indication seen by the host
  output logic fault_seen_out
);
  // ----------------------------------------------------------------
  // Pin watch
  // ----------------------------------------------------------------
  // Any low pin means a fault or warning to look up over the bus
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      fault_seen_out <= 1'b0;
    end else begin
      fault_seen_out <= !(fault_alarm_n_in && fault_warning_n_in);
    end
  end
endmodule

// [testbench/gate_driver_fault_report_mask_test.sv]
// Self-checking bench for the fault report routing block.
// Assumes the register port timing and reset values of the package.
`timescale 1ns/1ps
module gate_driver_fault_report_mask_test
  import gdf_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_in, rst_in, wr, wsel, rsel, clr, gv, warn_in;
  logic alarm_n, warn_n, shut, gm_act, otw, cfg_flt, seen;
  logic [15:0] wdata, rdata, m, fs;
  logic [13:0] f, det;
  logic [1:0] gm_st;
  logic [7:0] cs, cs0;
  int n_fail, n_compared;

  // Design and host model
  gdf_fault_report i_dut (
    .clk_in(clk_in), .rst_in(rst_in), .cfg_wr_in(wr),
    .cfg_wr_sel_in(wsel), .cfg_wdata_in(wdata), .cfg_rd_sel_in(rsel),
    .cfg_fault_clr_in(clr), .cfg_rdata_out(rdata),
    .short_circuit_in(f[13]), .overcurrent_in(f[12]),
    .gate_monitor_in(f[11]), .gate_voltage_high_in(gv),
    .supply_undervoltage_in(f[10]), .supply_overvoltage_in(f[9]),
    .switch_overtemp_in(f[8]), .driver_overtemp_in(f[7]),
    .driver_overtemp_warn_in(warn_in), .internal_link_in(f[6]),
    .config_checksum_in(f[5]), .trim_checksum_in(f[4]),
    .internal_regulator_in(f[3]), .self_test_in(f[2]),
    .regulator_ilimit_in(f[1]), .clock_monitor_in(f[0]),
    .fault_alarm_n_out(alarm_n), .fault_warning_n_out(warn_n),
    .secondary_shutdown_out(shut),
    .gate_monitor_failsafe_active_out(gm_act),
    .gate_monitor_failsafe_state_out(gm_st),
    .driver_overtemp_warning_out(otw), .config_fault_out(cfg_flt),
    .detected_faults_out(det), .secondary_config_checksum_out(cs)
  );
  gdf_host_monitor i_host (
    .clk_in(clk_in), .rst_in(rst_in), .fault_alarm_n_in(alarm_n),
    .fault_warning_n_in(warn_n), .fault_seen_out(seen)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Expected {alarm_n, warning_n} from masks, faults and gate state
  function automatic logic [1:0] exp_pins(logic [15:0] mk,
                                          logic [13:0] fv, logic g);
    logic a, w, rep;
    a = (fv[13] & !mk[14]) | (fv[12] & !mk[13]);
    a = a | (fv[11] & (mk[12:11] == 2'b01));
    w = (fv[11] & (mk[12:11] == 2'b10)) | (g & (mk[12:11] == 2'b11));
    for (int i = 0; i <= 10; i++) begin
      rep = fv[i] & (mk[i] == (i == 8 || i == 6));
      a = a | rep;
      if (i == 4 || i == 2) begin
        w = w | rep;
      end
    end
    return {!a, !w};
  endfunction

  // Expected checksum of {masks, failsafe}, MSB first
  function automatic logic [7:0] exp_crc(logic [31:0] d);
    logic [7:0] c;
    c = GDF_CRC_INIT;
    for (int i = 31; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? GDF_CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (exp !== got) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr_reg(logic sel, logic [15:0] d);
    @(posedge clk_in);
    wr <= 1'b1;
    wsel <= sel;
    wdata <= d;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(logic sel, logic [15:0] exp);
    @(posedge clk_in);
    rsel <= sel;
    repeat (2) @(posedge clk_in);
    #1;
    chk("rdata", exp, rdata);
  endtask

  // Drive detector levels, then let pins and host model settle
  task automatic apply(logic [13:0] fv, logic g, logic w);
    @(posedge clk_in);
    f <= fv;
    gv <= g;
    warn_in <= w;
    repeat (2) @(posedge clk_in);
    #1;
  endtask

  task automatic check_all();
    logic [1:0] p;
    logic [15:0] ea;
    p = exp_pins(m, f, gv);
    ea = 16'(p[1]);
    chk("alarm_n", ea, 16'(alarm_n));
    chk("checksum", 16'(exp_crc({m, fs})), 16'(cs));
    chk("warn_n", 16'(p[0]), 16'(warn_n));
    chk("detected", 16'(f), 16'(det));
    chk("shutdown", 16'(f[7]), 16'(shut));
    chk("gm_active", 16'(f[11]), 16'(gm_act));
    chk("gm_state", 16'(f[11] ? fs[3:2] : 2'h3), 16'(gm_st));
    chk("otw", 16'(warn_in & fs[15]), 16'(otw));
    chk("host_seen", 16'(!(p[1] & p[0])), 16'(seen));
    chk("cfg_fault", 16'h0, 16'(cfg_flt));
  endtask

  task automatic wrap_up();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    n_fail++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] tbl [4];
    tbl = '{16'h8940, 16'hFFFF, 16'h0000, 16'h1000};
    {rst_in, wr, wsel, rsel, clr, gv, warn_in} = 7'h40;
    wdata = 16'h0000;
    f = 14'h0000;
    n_fail = 0;
    n_compared = 0;
    void'($urandom(32'h030dc243));
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    m = 16'h8940;
    fs = 16'hC008;
    rd_reg(1'b0, 16'h8940);
    rd_reg(1'b1, 16'hC008);
    apply(14'h0000, 1'b0, 1'b1);
    check_all();
    $display("test reset done");
    // Every single fault and the live gate state under each routing
    foreach (tbl[k]) begin
      m = tbl[k];
      wr_reg(1'b0, m);
      for (int i = 0; i <= 14; i++) begin
        apply(i < 14 ? 14'(1 << i) : 14'h0000, i == 14, i[0]);
        check_all();
      end
    end
    $display("test single faults done");
    repeat (200) begin
      m = 16'($urandom);
      fs = 16'($urandom) & 16'hFBFF;
      wr_reg(1'b0, m);
      wr_reg(1'b1, fs);
      rd_reg(1'b0, m);
      rd_reg(1'b1, fs);
      apply(14'($urandom & $urandom), 1'($urandom), 1'($urandom));
      check_all();
    end
    $display("test random done");
    // Spare bit is covered by the checksum but raises no fault
    m = 16'h8940;
    wr_reg(1'b0, m);
    apply(14'h0000, 1'b0, 1'b0);
    cs0 = cs;
    m = 16'h0940;
    wr_reg(1'b0, m);
    apply(14'h0000, 1'b0, 1'b0);
    chk("crc_moved", 16'h1, 16'(cs !== cs0));
    check_all();
    $display("test spare done");
    // Reserved write sets the sticky fault, masked or not by bit 5
    for (int k = 0; k < 2; k++) begin
      m = k ? 16'h0960 : 16'h0940;
      wr_reg(1'b0, m);
      wr_reg(1'b1, fs | 16'h0400);
      wr_reg(1'b1, fs);
      apply(14'h0000, 1'b0, 1'b0);
      chk("cfg_fault", 16'h1, 16'(cfg_flt));
      chk("alarm_n", 16'(k), 16'(alarm_n));
      @(posedge clk_in);
      clr <= 1'b1;
      @(posedge clk_in);
      clr <= 1'b0;
      apply(14'h0000, 1'b0, 1'b0);
      check_all();
    end
    // Reserved write and clear in one cycle: the set wins
    @(posedge clk_in);
    wr <= 1'b1;
    wsel <= 1'b1;
    wdata <= fs | 16'h0400;
    clr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
    clr <= 1'b0;
    wr_reg(1'b1, fs);
    apply(14'h0000, 1'b0, 1'b0);
    chk("cfg_fault", 16'h1, 16'(cfg_flt));
    @(posedge clk_in);
    clr <= 1'b1;
    @(posedge clk_in);
    clr <= 1'b0;
    apply(14'h0000, 1'b0, 1'b0);
    check_all();
    $display("test reserved write done");
    // Reset in mid-run restores both registers
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    m = 16'h8940;
    fs = 16'hC008;
    rd_reg(1'b0, m);
    rd_reg(1'b1, fs);
    apply(14'h0000, 1'b0, 1'b1);
    check_all();
    $display("test mid reset done");
    wrap_up();
  end
endmodule
